/* File: core/infrared_pulse_endec.sv */
module infrared_pulse_endec (
  input  wire logic i_clk,
  input  wire logic i_rstn,
  input  wire logic i_infrared_codec_enable,
  input  wire logic i_baud_tick,
  input  wire logic i_uart_tx,
  input  wire logic i_rx_pin,
  output logic      o_tx_pin,
  output logic      o_uart_rx
);

  ////////////////////////////////////////////////////////////////////////
  // pin synchroniser: three flops, change counts when stages 2 and 3 agree
  logic [2:0] rx_sync_q;
  logic       rx_clean_q;
  logic       rx_clean_prev_q;
  wire        agree_w = rx_sync_q[1] == rx_sync_q[2];

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      rx_sync_q       <= 3'h7;
      rx_clean_q      <= 1'b1;
      rx_clean_prev_q <= 1'b1;
    end else begin
      rx_sync_q       <= {rx_sync_q[1:0], i_rx_pin};
      if (agree_w) rx_clean_q <= rx_sync_q[2];
      rx_clean_prev_q <= rx_clean_q;
    end
  end

  // the transceiver's pulses show as active-high on the pulse line;
  // a falling edge ends a pulse
  wire fall_w = rx_clean_prev_q & ~rx_clean_q;

  ////////////////////////////////////////////////////////////////////////
  // encoder
  logic enc_pulse_w;
  logic enc_busy_w;

  irda_pulse_encoder u_enc (
    .i_clk    (i_clk),
    .i_rstn   (i_rstn),
    .i_enable (i_infrared_codec_enable),
    .i_tick   (i_baud_tick),
    .i_bit    (i_uart_tx),
    .o_pulse  (enc_pulse_w),
    .o_busy   (enc_busy_w)
  );

  ////////////////////////////////////////////////////////////////////////
  // decoder: 0..15 counter, restarted on a falling edge when idle or in the window
  irda_endec_pkg::rx_state_type state_q;
  irda_endec_pkg::rx_state_type state_d;
  logic [3:0] cnt_q;
  logic       seen_q;
  logic       dec_q;

  // receive is ignored while the uart drives a zero or a frame still runs;
  // the frame flag alone drops for one tick between back-to-back zeros
  wire        rx_edge_w  = fall_w & ~enc_busy_w & i_uart_tx;
  wire  [3:0] cnt_nx_w   = cnt_q + 4'h1;
  // any baud divisor works; only the tick pulse paces us
  wire        at_upd_w   = i_baud_tick &&
                           (cnt_q == irda_endec_pkg::RX_UPDATE_CNT);
  wire        win_open_w = (cnt_q >= irda_endec_pkg::RX_WINDOW_CNT);
  wire        in_win_w   = (state_q == irda_endec_pkg::RX_WINDOW) |
                           ((state_q == irda_endec_pkg::RX_FIRST) &
                            win_open_w);

  // next state of the window tracker
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      irda_endec_pkg::RX_IDLE:
        if (rx_edge_w) state_d = irda_endec_pkg::RX_FIRST;
      irda_endec_pkg::RX_FIRST:
        if (rx_edge_w && win_open_w) state_d = irda_endec_pkg::RX_FIRST;
        else if (i_baud_tick && cnt_q == irda_endec_pkg::CNT_LAST)
          state_d = irda_endec_pkg::RX_WINDOW;
      irda_endec_pkg::RX_WINDOW:
        if (rx_edge_w) state_d = irda_endec_pkg::RX_FIRST;
        else if (at_upd_w) state_d = irda_endec_pkg::RX_IDLE;
    endcase
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      state_q <= irda_endec_pkg::RX_IDLE;
      cnt_q   <= irda_endec_pkg::CNT_RESET;
      seen_q  <= 1'b0;
    end else if (!i_infrared_codec_enable) begin
      state_q <= irda_endec_pkg::RX_IDLE;
      cnt_q   <= irda_endec_pkg::CNT_RESET;
      seen_q  <= 1'b0;
    end else begin
      state_q <= state_d;
      if (rx_edge_w && (state_q == irda_endec_pkg::RX_IDLE || in_win_w))
        cnt_q <= irda_endec_pkg::CNT_RESET;
      else if (i_baud_tick && state_q != irda_endec_pkg::RX_IDLE)
        cnt_q <= cnt_nx_w;
      // pulse memory: set at the edge, consumed at count 8
      if (rx_edge_w) seen_q <= 1'b1;
      else if (at_upd_w) seen_q <= 1'b0;
    end
  end

  // level rebuilt on the baud clock, nine ticks after the pulse's falling edge
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      dec_q <= irda_endec_pkg::UART_RX_RESET;
    end else if (!i_infrared_codec_enable || 
                 state_q == irda_endec_pkg::RX_IDLE) begin
      dec_q <= 1'b1;
    end else if (at_upd_w) begin
      dec_q <= ~(seen_q | rx_edge_w);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // pin and uart muxing; both outputs registered once
  logic tx_pin_q;
  logic uart_rx_q;
  wire  tx_sel_w = i_infrared_codec_enable ? enc_pulse_w : i_uart_tx;
  wire  rx_sel_w = i_infrared_codec_enable ? dec_q : rx_clean_q;

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      tx_pin_q  <= irda_endec_pkg::IR_TX_RESET;
      uart_rx_q <= irda_endec_pkg::UART_RX_RESET;
    end else begin
      tx_pin_q  <= tx_sel_w;
      uart_rx_q <= rx_sel_w;
    end
  end

  assign o_tx_pin  = tx_pin_q;
  assign o_uart_rx = uart_rx_q;

endmodule

/* File: core/irda_endec_pkg.sv */
package irda_endec_pkg;

  localparam int unsigned BIT_CLOCKS     = 16;
  localparam logic [3:0]  TX_PULSE_START = 4'h7;
  localparam logic [3:0]  TX_PULSE_END   = 4'ha;
  localparam logic [3:0]  RX_UPDATE_CNT  = 4'h8;
  localparam logic [3:0]  RX_WINDOW_CNT  = 4'hc;
  localparam logic [3:0]  CNT_RESET      = 4'h0;
  localparam logic [3:0]  CNT_LAST       = 4'hf;
  localparam logic        UART_RX_RESET  = 1'b1;
  localparam logic        IR_TX_RESET    = 1'b0;

  // uart side signals as one bundle
  typedef struct packed {
    logic tx;
    logic baud_tick;
  } uart_out_type;

  typedef enum logic [1:0] {
    RX_IDLE,
    RX_FIRST,
    RX_WINDOW
  } rx_state_type;

endpackage

/* File: core/irda_pulse_encoder.sv */
module irda_pulse_encoder (
  input  wire logic i_clk,
  input  wire logic i_rstn,
  input  wire logic i_enable,
  input  wire logic i_tick,
  input  wire logic i_bit,
  output logic      o_pulse,
  output logic      o_busy
);

  logic [3:0] cnt_q;
  logic       bit_q;
  logic       busy_q;
  logic       pulse_q;
  wire        start_w  = i_tick & ~busy_q & ~i_bit;
  wire  [3:0] cnt_nx_w = cnt_q + 4'h1;
  wire        hi_w     = (cnt_nx_w >= irda_endec_pkg::TX_PULSE_START) &&
                         (cnt_nx_w < irda_endec_pkg::TX_PULSE_END);

  // one bit frame of sixteen ticks; a zero bit gives a 7/3/6 shape
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      cnt_q   <= irda_endec_pkg::CNT_RESET;
      bit_q   <= 1'b1;
      busy_q  <= 1'b0;
      pulse_q <= irda_endec_pkg::IR_TX_RESET;
    end else if (!i_enable) begin
      cnt_q   <= irda_endec_pkg::CNT_RESET;
      busy_q  <= 1'b0;
      pulse_q <= 1'b0;
    end else if (i_tick) begin
      if (!busy_q) begin
        cnt_q   <= irda_endec_pkg::CNT_RESET;
        bit_q   <= i_bit;
        busy_q  <= start_w;
        pulse_q <= 1'b0;
      end else begin
        cnt_q   <= cnt_nx_w;
        // frame ends on its sixteenth tick, next bit taken on the one after
        busy_q  <= (cnt_nx_w != irda_endec_pkg::CNT_LAST);
        pulse_q <= hi_w & ~bit_q;
      end
    end
  end

  assign o_pulse = pulse_q;
  assign o_busy  = busy_q;

endmodule

/* File: sim/infrared_pulse_endec_asserts.sv */
module infrared_pulse_endec_asserts (
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic i_infrared_codec_enable,
  input wire logic i_baud_tick,
  input wire logic i_uart_tx,
  input wire logic i_rx_pin,
  input wire logic o_tx_pin,
  input wire logic o_uart_rx
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [5:0] age_q, hi_q, one_q, fall_q;
  wire        en = i_infrared_codec_enable && age_q[5];
  ////////////////////////////////
  // cycles enabled, ticks while pulse high or tx one, ticks since rx fell
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      age_q  <= 6'h00;
      hi_q   <= 6'h00;
      one_q  <= 6'h00;
      fall_q <= 6'h3f;
    end else begin
      age_q  <= i_infrared_codec_enable ? age_q + 6'(~&age_q) : 6'h00;
      hi_q   <= o_tx_pin ? hi_q + 6'(i_baud_tick) : 6'h00;
      one_q  <= i_uart_tx ? one_q + 6'(i_baud_tick & ~&one_q) : 6'h00;
      fall_q <= $fell(i_rx_pin) ? 6'h00 : fall_q + 6'(i_baud_tick & ~&fall_q);
    end
  end
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rstn);
  // pass-through pin held still for eight cycles
  sequence pin_settled;
    (!i_infrared_codec_enable && $stable(i_rx_pin)) [*8];
  endsequence
  a_reset_levels: assert property (
    $rose(i_rstn) |-> !o_tx_pin && o_uart_rx)
    else $error("bad level after reset");
  a_pulse_width: assert property (
    en && $fell(o_tx_pin) |-> hi_q == 6'h03)
    else $error("pulse not three ticks wide");
  a_one_low: assert property (
    en && one_q > 6'h10 |-> !o_tx_pin)
    else $error("pulse during one bit");
  a_rx_lag: assert property (
    en && $fell(o_uart_rx) |-> fall_q inside {[6'h07:6'h09]})
    else $error("decoded zero at wrong count");
  a_rx_return: assert property (
    en && $rose(o_uart_rx) |-> fall_q inside {[6'h17:6'h19]})
    else $error("window closed at wrong count");
  a_rx_idle: assert property (
    en && fall_q > 6'h1d |-> o_uart_rx)
    else $error("decoder not idle high");
  a_pass_tx: assert property (
    !i_infrared_codec_enable && !$past(i_infrared_codec_enable) &&
    $past(i_rstn) |-> o_tx_pin == $past(i_uart_tx))
    else $error("tx pass-through wrong");
  a_pass_rx: assert property (
    pin_settled |-> o_uart_rx == i_rx_pin)
    else $error("rx pass-through wrong");
endmodule

bind infrared_pulse_endec infrared_pulse_endec_asserts u_checks (.i_clk(i_clk),
  .i_rstn(i_rstn), .i_infrared_codec_enable(i_infrared_codec_enable),
  .i_baud_tick(i_baud_tick), .i_uart_tx(i_uart_tx), .i_rx_pin(i_rx_pin),
  .o_tx_pin(o_tx_pin), .o_uart_rx(o_uart_rx));

/* File: sim/ir_transceiver_model.sv */
module ir_transceiver_model (
  input  wire logic       i_clk,
  input  wire logic       i_tick,
  input  wire logic       i_send,
  input  wire logic       i_bit,
  output logic      [3:0] o_phase,
  output logic            o_rx_line
);
  timeunit 1ns;
  timeprecision 1ps;
  logic zero_q = 1'b0;
  initial o_phase = 4'h0;
  // slot phase per tick; next bit taken as a slot ends
  always @(posedge i_clk) begin
    if (i_tick) o_phase <= o_phase + 4'h1;
    if (i_tick && o_phase == 4'hf) zero_q <= i_send && !i_bit;
  end
  // a zero lights the line for ticks 7 to 9, dark otherwise
  assign o_rx_line = zero_q && o_phase inside {[4'h7:4'h9]};
endmodule

/* File: sim/infrared_pulse_endec_test.sv */
module infrared_pulse_endec_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic       clk = 0, rstn = 0, en = 0, tick = 0, utx = 1, raw = 0;
  logic       send = 0, bv = 1, prev = 1;
  logic [3:0] phase;
  logic       q[$];
  wire        ir, o_tx, o_rx;
  wire        pin = en ? ir : raw;
  int         mismatches = 0, n_compared = 0, div = 0, cyc = 0;
  int         hi = 0, h0, zeros = 0;
  infrared_pulse_endec u_infrared_pulse_endec (.i_clk(clk), .i_rstn(rstn),
    .i_infrared_codec_enable(en), .i_baud_tick(tick), .i_uart_tx(utx),
    .i_rx_pin(pin), .o_tx_pin(o_tx), .o_uart_rx(o_rx));
  ir_transceiver_model u_ir_transceiver_model (.i_clk(clk), .i_tick(tick),
    .i_send(send), .i_bit(bv), .o_phase(phase), .o_rx_line(ir));
  initial forever #12.5 clk = ~clk;
  ////////////////////////////////
  // baud tick every 8 clocks, ticks of high pulse output, hang guard
  always @(negedge clk) begin
    div  <= (div + 1) % 8;
    tick <= div == 7;
    hi   <= hi + int'(tick && o_tx);
    cyc  <= cyc + 1;
    if (cyc == 12000) begin
      mismatches++;
      give_verdict();
    end
  end
  task check(string what, logic exp, logic got);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %s expected %b seen %b", what, exp, got);
    end
  endtask
  task ticks(int n);
    repeat (n) @(posedge clk iff tick);
    @(negedge clk);
  endtask
  // one far-side slot; mid-slot the uart sees the slot before
  task rx_slot(logic v);
    bv <= v;
    while (phase != 4'hf) ticks(1);
    ticks(11);
    check("uart rx", prev, o_rx);
    prev = v;
  endtask
  task give_verdict;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // reset, pass-through, encode, decode, half duplex
  initial begin
    void'($urandom(32'h0eecf212));
    repeat (2) @(negedge clk);
    check("tx in reset", 1'b0, o_tx);
    check("rx in reset", 1'b1, o_rx);
    rstn = 1;
    repeat (12) begin
      utx = 1'($urandom);
      raw = 1'($urandom);
      repeat (8) @(negedge clk);
      check("tx pass", utx, o_tx);
      check("rx pass", raw, o_rx);
    end
    $display("pass-through done");
    en = 1;
    utx = 1;
    ticks(4);
    h0 = hi;
    repeat (12) begin
      utx = 1'($urandom);
      zeros += int'(!utx);
      ticks(16);
    end
    utx = 1;
    ticks(20);
    check("pulse ticks", 1'b1, hi - h0 == 3 * zeros);
    $display("encode done");
    repeat (16) q.push_back(1'($urandom));
    q.push_back(1'b1);
    q.push_back(1'b1);
    send <= 1;
    foreach (q[i]) rx_slot(q[i]);
    $display("decode done");
    utx = 0;
    ticks(2);
    repeat (4) begin
      prev = 1;
      rx_slot(1'b0);
    end
    $display("half duplex done");
    give_verdict();
  end
endmodule
